// *** shared/sli_pkg.sv ***
// shared constants and types for the status led indicator block
package sli_pkg;

    // fieldbus slave states
    typedef enum logic [1:0]
    {
        SLI_FB_INIT = 2'h0,
        SLI_FB_PREOP = 2'h1,
        SLI_FB_SAFEOP = 2'h3,
        SLI_FB_OP = 2'h2
    } sli_fb_state_e;

    // fieldbus error classes
    typedef enum logic [1:0]
    {
        SLI_ERR_NONE = 2'h0,
        SLI_ERR_SETTING = 2'h1,
        SLI_ERR_DATA = 2'h3,
        SLI_ERR_WDOG = 2'h2
    } sli_fb_err_e;

    // per-axis status sources
    typedef struct packed
    {
        logic ctrl_supply_ok;
        logic alarm;
        logic info;
        logic remote_op;
        logic simulating;
        logic motor_24v;
        logic ext_switch;
    } sli_axis_s;

    // shared blink phases from the timebase
    typedef struct packed
    {
        logic blink;
        logic single_flash;
        logic double_flash;
        logic flicker;
        logic two_blink;
        logic [1:0] sim_step;
    } sli_phase_s;

    // timebase figures at 200 MHz
    localparam int unsigned SLI_CLK_HZ = 200_000_000;
    localparam int unsigned SLI_TICK_US = 50_000;
    localparam int unsigned SLI_TICK_CYC = SLI_CLK_HZ / 1_000_000 * SLI_TICK_US;
    localparam int unsigned SLI_FRAME_TICKS = 24;
    localparam int unsigned SLI_FLICKER_TICKS = 1;
    localparam logic [3:0] SLI_NODE_DEFAULT = 4'h0;

    // interrupt status and mask bit positions
    localparam int unsigned SLI_EV_FB_ERR = 0;
    localparam int unsigned SLI_EV_COMB_ERR = 1;
    localparam int unsigned SLI_EV_OVERHEAT = 2;
    localparam int unsigned SLI_EV_AXIS_ALARM = 3;
    localparam int unsigned SLI_EV_W = 4;

    // register offsets
    localparam logic [3:0] SLI_REG_STATUS = 4'h0;
    localparam logic [3:0] SLI_REG_MASK = 4'h4;
    localparam logic [3:0] SLI_REG_STATE = 4'h8;
    localparam logic [3:0] SLI_REG_FORCE = 4'hc;
    localparam logic [SLI_EV_W-1:0] SLI_MASK_RST = 4'h0;

endpackage : sli_pkg

// *** rtl/sli_timebase.sv ***
// common blink timebase shared by every blinking indicator
`timescale 1ns/10ps
`default_nettype none
module sli_timebase
    import sli_pkg::*;
#(
    parameter int unsigned TICK_CYC = SLI_TICK_CYC,
    parameter int unsigned FRAME_TICKS = SLI_FRAME_TICKS
)
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    output sli_phase_s phase
);
    logic [31:0] cyc_q;
    logic [7:0]  tick_q;
    logic [1:0]  sim_q;
    logic        flk_q;
    logic        tick;

    assign tick = (cyc_q == TICK_CYC - 1);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            cyc_q <= 32'h0;
        else if (tick)
            cyc_q <= 32'h0;
        else
            cyc_q <= cyc_q + 32'h1;
    end

    // frame of ticks: all patterns but flicker derive from one counter so phases agree; flicker toggles every tick
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            tick_q <= 8'h0;
            sim_q  <= 2'h0;
            flk_q  <= 1'b0;
        end
        else if (tick)
        begin
            flk_q <= ~flk_q;
            if (tick_q == 8'(FRAME_TICKS - 1))
            begin
                tick_q <= 8'h0;
                sim_q  <= (sim_q == 2'h2) ? 2'h0 : sim_q + 2'h1;
            end
            else
                tick_q <= tick_q + 8'h1;
        end
    end

    // frame split in twelfths: blink half on, flashes one slot on
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            phase <= '0;
        else
        begin
            phase.blink        <= (tick_q % 8'd4) < 8'd2;
            phase.single_flash <= tick_q < 8'(FRAME_TICKS / 12);
            phase.double_flash <= (tick_q < 8'(FRAME_TICKS / 12)) ||
                                  (tick_q >= 8'(FRAME_TICKS / 6) &&
                                   tick_q < 8'(FRAME_TICKS / 4));
            phase.two_blink    <= (tick_q < 8'(FRAME_TICKS / 6)) ||
                                  (tick_q >= 8'(FRAME_TICKS / 3) &&
                                   tick_q < 8'(FRAME_TICKS / 2));
            phase.flicker      <= flk_q;
            phase.sim_step     <= sim_q;
        end
    end
endmodule : sli_timebase
`default_nettype wire

// *** rtl/sli_status_led.sv ***
// front panel status indication for the multi-axis driver
// How it works
// RL1: the green run led is off in init, blinks in pre-operational, single-flashes in safe-operational, lit in operational.
// RL2: the red fault led is off with no error, blinks on a setting error, single-flashes on data error, double-flashes on watchdog timeout.
// RL3: the communication-axis alarm led is off with no alarm, blinks on an alarm, and is lit on a processor error.
// RL4: each link led is off with no link, lit with link, and flickers while traffic runs.
// RL5: the main power led follows the presence of the main supply.
// RL6: each axis lights its power led while its control supply is normal, alarm led off in normal operation.
// RL7: an axis with an alarm keeps power lit and blinks its alarm led.
// RL8: information or remote operation blinks power and alarm together twice, repeating.
// RL9: simulated operation steps power, then alarm, then both, repeating.
// RL10: the regeneration led is lit while regeneration is active.
// RL11: the thermal led is lit while the resistor reports overheat.
// RL12: the node address comes from tens and units rotary switches, which default to zero.
// RL13: pressing an axis extension switch asserts the input function assigned to it.
// RL14: a 24 V motor on any axis with a 48 V main supply raises the combination alarm.
// RL15: all patterns come from one shared timebase whose periods are parameters.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sli_status_led
    import sli_pkg::*;
#(
    parameter int unsigned AXES = 4,
    parameter int unsigned PORTS = 2,
    parameter int unsigned TICK_CYC = SLI_TICK_CYC,
    parameter int unsigned FRAME_TICKS = SLI_FRAME_TICKS
)
(
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // register port
    input  wire logic [3:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [31:0]               reg_rdata,
    output logic                      irq,
    // status sources on the system clock
    input  wire sli_fb_state_e        fb_state,
    input  wire sli_fb_err_e          fb_err,
    input  wire logic                 comm_alarm,
    input  wire logic                 cpu_error,
    input  wire logic [PORTS-1:0]     link_up,
    input  wire logic [PORTS-1:0]     link_traffic,
    input  wire logic                 regen_active,
    input  wire sli_axis_s [AXES-1:0] axis_in,
    // pins from outside the clock domain
    input  wire logic                 main_supply_pin,
    input  wire logic                 main_48v_pin,
    input  wire logic                 overheat_pin,
    input  wire logic [3:0]           node_address_switches_tens,
    input  wire logic [3:0]           node_address_switches_units,
    input  wire logic [AXES-1:0]      extension_push_switch,
    // indicators and derived outputs
    output logic                      run_led,
    output logic                      fault_led,
    output logic                      comm_alarm_led,
    output logic [PORTS-1:0]          link_led,
    output logic                      main_power_led,
    output logic [AXES-1:0]           axis_power_led,
    output logic [AXES-1:0]           axis_alarm_led,
    output logic                      regen_active_indicator,
    output logic                      resistor_overheat_indicator,
    output logic [6:0]                node_address,
    output logic [AXES-1:0]           ext_input_assert,
    output logic                      comb_error_alarm
);
    sli_phase_s          ph;
    logic [2:0]          pin_s1_q;
    logic [2:0]          pin_s2_q;
    logic [7:0]          sw_s1_q;
    logic [7:0]          sw_s2_q;
    logic [AXES-1:0]     ext_s1_q;
    logic [AXES-1:0]     ext_s2_q;
    logic [SLI_EV_W-1:0] status_q;
    logic [SLI_EV_W-1:0] mask_q;
    logic [SLI_EV_W-1:0] ev;
    logic [SLI_EV_W-1:0] ev_prev_q;
    logic [SLI_EV_W-1:0] ev_rise;
    logic [AXES-1:0]     ext_en_q;
    logic [AXES-1:0]     comb_ax;
    logic                any_axis_alarm;
    logic                main_ok;
    logic                main_48v;
    logic                overheat;

    // shared timebase [RL15]
    sli_timebase #(
        .TICK_CYC    (TICK_CYC),
        .FRAME_TICKS (FRAME_TICKS)
    ) u_tb (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .phase   (ph)
    );

    // two-stage synchronisers for pins
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            sw_s1_q  <= 8'h0;
            sw_s2_q  <= 8'h0;
            ext_s1_q <= '0;
            ext_s2_q <= '0;
        end
        else
        begin
            pin_s1_q <= {overheat_pin, main_48v_pin, main_supply_pin};
            pin_s2_q <= pin_s1_q;
            sw_s1_q  <= {node_address_switches_tens, node_address_switches_units};
            sw_s2_q  <= sw_s1_q;
            ext_s1_q <= extension_push_switch;
            ext_s2_q <= ext_s1_q;
        end
    end

    assign main_ok  = pin_s2_q[0];
    assign main_48v = pin_s2_q[1];
    assign overheat = pin_s2_q[2];

    // communication axis indicators
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            run_led        <= 1'b0;
            fault_led      <= 1'b0;
            comm_alarm_led <= 1'b0;
        end
        else
        begin
            case (fb_state)
                SLI_FB_INIT:   run_led <= 1'b0;              // [RL1]
                SLI_FB_PREOP:  run_led <= ph.blink;          // [RL1]
                SLI_FB_SAFEOP: run_led <= ph.single_flash;   // [RL1]
                SLI_FB_OP:     run_led <= 1'b1;              // [RL1]
                default:       run_led <= 1'b0;
            endcase
            case (fb_err)
                SLI_ERR_NONE:    fault_led <= 1'b0;             // [RL2]
                SLI_ERR_SETTING: fault_led <= ph.blink;         // [RL2]
                SLI_ERR_DATA:    fault_led <= ph.single_flash;  // [RL2]
                SLI_ERR_WDOG:    fault_led <= ph.double_flash;  // [RL2]
                default:         fault_led <= 1'b0;
            endcase
            // processor error outranks an ordinary alarm
            if (cpu_error)
                comm_alarm_led <= 1'b1;                        // [RL3]
            else
                comm_alarm_led <= comm_alarm & ph.blink;       // [RL3]
        end
    end

    // link/activity per port
    genvar p;
    generate
        for (p = 0; p < PORTS; p++)
        begin : g_port
            always_ff @(posedge ref_clk)
            begin
                if (!rst_n)
                    link_led[p] <= 1'b0;
                else if (!link_up[p])
                    link_led[p] <= 1'b0;                      // [RL4]
                else if (link_traffic[p])
                    link_led[p] <= ph.flicker;                // [RL4]
                else
                    link_led[p] <= 1'b1;                      // [RL4]
            end
        end
    endgenerate

    // supply, regeneration and thermal indicators
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            main_power_led              <= 1'b0;
            regen_active_indicator      <= 1'b0;
            resistor_overheat_indicator <= 1'b0;
            node_address                <= 7'(SLI_NODE_DEFAULT);
        end
        else
        begin
            main_power_led              <= main_ok;           // [RL5]
            regen_active_indicator      <= regen_active;      // [RL10]
            resistor_overheat_indicator <= overheat;          // [RL11]
            // tens digit times ten plus units digit [RL12]
            node_address <= 7'(sw_s2_q[7:4]) * 7'd10 + 7'(sw_s2_q[3:0]);
        end
    end

    // driver axis indicators, extension switch and supply combination check
    genvar a;
    generate
        for (a = 0; a < AXES; a++)
        begin : g_axis
            assign comb_ax[a] = axis_in[a].motor_24v & main_48v;  // [RL14]

            always_ff @(posedge ref_clk)
            begin
                if (!rst_n)
                begin
                    axis_power_led[a]   <= 1'b0;
                    axis_alarm_led[a]   <= 1'b0;
                    ext_input_assert[a] <= 1'b0;
                end
                else
                begin
                    // switch acts as its assigned input while pressed, if enabled
                    ext_input_assert[a] <= ext_s2_q[a] & ext_en_q[a];  // [RL13]
                    if (!axis_in[a].ctrl_supply_ok)
                    begin
                        axis_power_led[a] <= 1'b0;
                        axis_alarm_led[a] <= 1'b0;
                    end
                    else if (axis_in[a].simulating)
                    begin
                        axis_power_led[a] <= ph.sim_step != 2'h1;   // [RL9]
                        axis_alarm_led[a] <= ph.sim_step != 2'h0;   // [RL9]
                    end
                    else if (axis_in[a].alarm)
                    begin
                        axis_power_led[a] <= 1'b1;                  // [RL7]
                        axis_alarm_led[a] <= ph.blink;              // [RL7]
                    end
                    else if (axis_in[a].info || axis_in[a].remote_op)
                    begin
                        axis_power_led[a] <= ph.two_blink;          // [RL8]
                        axis_alarm_led[a] <= ph.two_blink;          // [RL8]
                    end
                    else
                    begin
                        axis_power_led[a] <= 1'b1;                  // [RL6]
                        axis_alarm_led[a] <= 1'b0;                  // [RL6]
                    end
                end
            end
        end
    endgenerate

    assign any_axis_alarm = |comb_ax;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            comb_error_alarm <= 1'b0;
        else
            comb_error_alarm <= any_axis_alarm & main_ok;   // [RL14]
    end

    // events and their rising edges
    always_comb
    begin
        ev = '0;
        ev[SLI_EV_FB_ERR]     = fb_err != SLI_ERR_NONE;
        ev[SLI_EV_COMB_ERR]   = comb_error_alarm;
        ev[SLI_EV_OVERHEAT]   = overheat;
        ev[SLI_EV_AXIS_ALARM] = comm_alarm | cpu_error;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            ev_prev_q <= '0;
        else
            ev_prev_q <= ev;
    end

    assign ev_rise = ev & ~ev_prev_q;

    // sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            status_q <= '0;
        else if (reg_wr && reg_addr == SLI_REG_STATUS)
            status_q <= (status_q & ~reg_wdata[SLI_EV_W-1:0]) | ev_rise;
        else
            status_q <= status_q | ev_rise;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            mask_q   <= SLI_MASK_RST;
            ext_en_q <= '0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == SLI_REG_MASK)
                mask_q <= reg_wdata[SLI_EV_W-1:0];
            if (reg_addr == SLI_REG_FORCE)
                ext_en_q <= reg_wdata[AXES-1:0];
        end
    end

    assign irq = |(status_q & mask_q);

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            reg_rdata <= 32'h0;
        else if (reg_rd)
        begin
            case (reg_addr)
                SLI_REG_STATUS: reg_rdata <= 32'(status_q);
                SLI_REG_MASK:   reg_rdata <= 32'(mask_q);
                SLI_REG_STATE:  reg_rdata <= {16'h0, 1'b0, node_address,
                                              main_ok, main_48v, overheat,
                                              fb_err, fb_state, comb_error_alarm};
                SLI_REG_FORCE:  reg_rdata <= 32'(ext_en_q);
                default:        reg_rdata <= 32'h0;
            endcase
        end
        else
            reg_rdata <= 32'h0;
    end
endmodule : sli_status_led
`default_nettype wire

// *** tb/sli_led_eye.sv ***
// front panel observer: counts lit cycles and toggles of each lamp
`timescale 1ns/10ps
`default_nettype none
module sli_led_eye
#(
    parameter int W = 7
)
(
    input  wire logic         ref_clk,
    input  wire logic         start,
    input  wire logic [W-1:0] leds,
    output logic [W-1:0][9:0] on_cnt,
    output logic [W-1:0][9:0] tog_cnt
);
    logic [W-1:0] prev_q;

    always_ff @(posedge ref_clk)
    begin
        prev_q <= leds;
        for (int i = 0; i < W; i++)
        begin
            on_cnt[i] <= start ? 10'h0 : on_cnt[i] + 10'(leds[i]);
            tog_cnt[i] <= start ? 10'h0 : tog_cnt[i] + 10'(leds[i] ^ prev_q[i]);
        end
    end
endmodule : sli_led_eye
`default_nettype wire

// *** tb/sli_status_led_asserts.sv ***
// port checks for the status led block
`timescale 1ns/10ps
`default_nettype none
module sli_status_led_asserts
    import sli_pkg::*;
#(
    parameter int unsigned AXES = 4,
    parameter int unsigned PORTS = 2
)
(
    input wire logic                 ref_clk,
    input wire logic                 rst_n,
    input wire logic                 reg_rd,
    input wire logic [31:0]          reg_rdata,
    input wire sli_fb_state_e        fb_state,
    input wire sli_fb_err_e          fb_err,
    input wire logic                 cpu_error,
    input wire logic [PORTS-1:0]     link_up,
    input wire logic [PORTS-1:0]     link_traffic,
    input wire logic                 regen_active,
    input wire sli_axis_s [AXES-1:0] axis_in,
    input wire logic                 main_supply_pin,
    input wire logic                 main_48v_pin,
    input wire logic                 overheat_pin,
    input wire logic [3:0]           node_address_switches_tens,
    input wire logic [3:0]           node_address_switches_units,
    input wire logic                 run_led,
    input wire logic                 fault_led,
    input wire logic                 comm_alarm_led,
    input wire logic [PORTS-1:0]     link_led,
    input wire logic                 main_power_led,
    input wire logic [AXES-1:0]      axis_power_led,
    input wire logic [AXES-1:0]      axis_alarm_led,
    input wire logic                 regen_active_indicator,
    input wire logic                 resistor_overheat_indicator,
    input wire logic [6:0]           node_address,
    input wire logic                 comb_error_alarm
);
    logic [2:0] up_q;
    logic       any24;

    // edges since reset
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            up_q <= 3'h0;
        else if (up_q != 3'h7)
            up_q <= up_q + 3'h1;
    end

    always_comb
    begin
        any24 = 1'b0;
        for (int i = 0; i < AXES; i++)
            any24 |= axis_in[i].motor_24v;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_pins_ok;
        up_q >= 3'h3;
    endsequence

    a_main_power: assert property
        (s_pins_ok |-> main_power_led == $past(main_supply_pin, 3))
        else $error("main led");
    a_overheat_led: assert property
        (s_pins_ok |-> resistor_overheat_indicator == $past(overheat_pin, 3))
        else $error("heat led");
    a_node_addr: assert property
        (s_pins_ok |-> node_address == 7'(10 * $past(node_address_switches_tens, 3)
            + $past(node_address_switches_units, 3)))
        else $error("node");
    a_comb_alarm: assert property
        (s_pins_ok |-> comb_error_alarm == ($past(main_48v_pin, 3)
            && $past(main_supply_pin, 3) && $past(any24)))
        else $error("comb");
    a_regen_led: assert property
        (regen_active_indicator == $past(regen_active))
        else $error("regen");
    a_run_lit: assert property
        ($past(fb_state) == SLI_FB_OP |-> run_led)
        else $error("run led");
    a_fault_dark: assert property
        ($past(fb_err) == SLI_ERR_NONE |-> !fault_led)
        else $error("fault led");
    a_cpu_lit: assert property
        ($past(cpu_error) |-> comm_alarm_led)
        else $error("cpu led");
    a_link_lit: assert property
        ($past(link_up[0] && !link_traffic[0]) |-> link_led[0])
        else $error("link led");
    a_axis_dark: assert property
        ($past(!axis_in[0].ctrl_supply_ok) |-> !axis_power_led[0] && !axis_alarm_led[0])
        else $error("axis dark");
    a_axis_normal: assert property
        ($past(axis_in[0]) == 7'h40 |-> axis_power_led[0] && !axis_alarm_led[0])
        else $error("axis normal");
    a_alarm_power: assert property
        ($past(axis_in[0]) == 7'h60 |-> axis_power_led[0])
        else $error("alarm power");
    a_rdata_idle: assert property
        (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("rdata idle");
endmodule : sli_status_led_asserts
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the status led block
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import sli_pkg::*;
;
    localparam int FRM = 4 * 24;
    logic                ref_clk, rst_n, start, reg_wr, reg_rd, irq, comm_alarm, cpu_error;
    logic                regen_active, main_supply_pin, main_48v_pin, overheat_pin, run_led;
    logic                fault_led, comm_alarm_led, main_power_led, regen_active_indicator;
    logic                resistor_overheat_indicator, comb_error_alarm;
    logic [3:0]          reg_addr, node_address_switches_tens, node_address_switches_units;
    logic [3:0]          extension_push_switch, axis_power_led, axis_alarm_led, ext_input_assert;
    logic [31:0]         reg_wdata, reg_rdata;
    logic [1:0]          link_up, link_traffic, link_led;
    sli_fb_state_e       fb_state;
    sli_fb_err_e         fb_err;
    sli_axis_s [3:0]     axis_in;
    logic [6:0]          node_address, eye_leds;
    logic [6:0][9:0]     eye_on, eye_tog;
    int                  fails, n_compared;

    sli_status_led #(.TICK_CYC(4)) uut (.*);

    assign eye_leds = {axis_power_led[0] & axis_alarm_led[0], link_led[0], axis_alarm_led[0],
                       axis_power_led[0], comm_alarm_led, fault_led, run_led};

    sli_led_eye #(.W(7)) eye (.ref_clk(ref_clk), .start(start), .leds(eye_leds),
                              .on_cnt(eye_on), .tog_cnt(eye_tog));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk("rdata", exp, reg_rdata);
        @(posedge ref_clk);
    endtask : rd

    // watch lamp b for n cycles
    task automatic pat(input int b, input int n, input int on, input int tg);
        repeat (4) @(posedge ref_clk);
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        repeat (n) @(posedge ref_clk);
        #1;
        chk($sformatf("lamp%0d lit", b), on, 32'(eye_on[b]));
        chk($sformatf("lamp%0d toggles", b), tg, 32'(eye_tog[b]));
        @(posedge ref_clk);
    endtask : pat

    task automatic t_reset();
        rd(SLI_REG_STATUS, 32'h0);
        rd(SLI_REG_MASK, 32'h0);
        rd(SLI_REG_FORCE, 32'h0);
        chk("node", 32'h0, 32'(node_address));
        chk("irq", 32'h0, 32'(irq));
    endtask : t_reset

    task automatic t_run();
        sli_fb_state_e st[4] = '{SLI_FB_INIT, SLI_FB_PREOP, SLI_FB_SAFEOP, SLI_FB_OP};
        sli_fb_err_e er[4] = '{SLI_ERR_NONE, SLI_ERR_SETTING, SLI_ERR_DATA, SLI_ERR_WDOG};
        int on[4] = '{0, 48, 8, 96};
        int tg[4] = '{0, 12, 2, 0};
        int fo[4] = '{0, 48, 8, 16};
        int ft[4] = '{0, 12, 2, 4};
        for (int i = 0; i < 4; i++)
        begin
            fb_state <= st[i];
            fb_err <= er[i];
            pat(0, FRM, on[i], tg[i]);
            pat(1, FRM, fo[i], ft[i]);
        end
        fb_err <= SLI_ERR_NONE;
    endtask : t_run

    task automatic t_comm();
        comm_alarm <= 1'b1;
        pat(2, FRM, 48, 12);
        cpu_error <= 1'b1;
        pat(2, FRM, 96, 0);
        comm_alarm <= 1'b0;
        cpu_error <= 1'b0;
        pat(2, FRM, 0, 0);
    endtask : t_comm

    task automatic t_link();
        link_up <= 2'h1;
        pat(5, FRM, 96, 0);
        link_traffic <= 2'h3;
        pat(5, FRM, 48, 24);
        link_up <= 2'h0;
        pat(5, FRM, 0, 0);
        link_traffic <= 2'h0;
    endtask : t_link

    task automatic t_axis();
        sli_axis_s cd[5] = '{7'h00, 7'h40, 7'h60, 7'h50, 7'h48};
        int pw[5] = '{0, 96, 96, 32, 32};
        int pt[5] = '{0, 0, 0, 4, 4};
        int al[5] = '{0, 0, 48, 32, 32};
        int at[5] = '{0, 0, 12, 4, 4};
        for (int i = 0; i < 5; i++)
        begin
            axis_in[0] <= cd[i];
            pat(3, FRM, pw[i], pt[i]);
            pat(4, FRM, al[i], at[i]);
            pat(6, FRM, al[i], at[i]);
        end
        axis_in[0] <= 7'h44;
        pat(3, 3 * FRM, 192, 2);
        pat(4, 3 * FRM, 192, 2);
        pat(6, 3 * FRM, 96, 2);
        axis_in[0] <= 7'h40;
    endtask : t_axis

    task automatic t_pins();
        main_supply_pin <= 1'b1;
        regen_active <= 1'b1;
        overheat_pin <= 1'b1;
        node_address_switches_tens <= 4'h9;
        node_address_switches_units <= 4'h7;
        extension_push_switch <= 4'h5;
        wr(SLI_REG_FORCE, 32'h6);
        repeat (3) @(posedge ref_clk);
        chk("main led", 32'h1, 32'(main_power_led));
        chk("regen led", 32'h1, 32'(regen_active_indicator));
        chk("heat led", 32'h1, 32'(resistor_overheat_indicator));
        chk("node", 32'h61, 32'(node_address));
        chk("ext", 32'h4, 32'(ext_input_assert));
        rd(SLI_REG_FORCE, 32'h6);
        rd(SLI_REG_STATE, 32'h61a4);
    endtask : t_pins

    task automatic t_irq();
        wr(SLI_REG_STATUS, 32'hf);
        wr(SLI_REG_MASK, 32'h2);
        rd(SLI_REG_MASK, 32'h2);
        rd(SLI_REG_STATUS, 32'h0);
        main_48v_pin <= 1'b1;
        axis_in[2] <= 7'h42;
        repeat (4) @(posedge ref_clk);
        chk("comb", 32'h1, 32'(comb_error_alarm));
        rd(SLI_REG_STATUS, 32'h2);
        chk("irq", 32'h1, 32'(irq));
        wr(SLI_REG_MASK, 32'h0);
        @(posedge ref_clk);
        chk("irq", 32'h0, 32'(irq));
        wr(SLI_REG_STATUS, 32'h2);
        wr(SLI_REG_MASK, 32'h2);
        rd(SLI_REG_STATUS, 32'h0);
        chk("irq", 32'h0, 32'(irq));
        main_48v_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk("comb", 32'h0, 32'(comb_error_alarm));
        rd(4'h2, 32'h0);
    endtask : t_irq

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial
    begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, comm_alarm, cpu_error, link_up} = '0;
        {link_traffic, regen_active, axis_in, main_supply_pin, main_48v_pin} = '0;
        {overheat_pin, node_address_switches_tens, node_address_switches_units} = '0;
        extension_push_switch = 4'h0;
        fb_state = SLI_FB_INIT;
        fb_err = SLI_ERR_NONE;
        start = 1'b0;
        rst_n = 1'b0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_run();
        t_comm();
        t_link();
        t_axis();
        t_pins();
        t_irq();
        print_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        print_verdict();
    end
endmodule : tb_top

bind sli_status_led sli_status_led_asserts #(.AXES(AXES), .PORTS(PORTS)) u_chk (.*);
`default_nettype wire
